// ==== inc/motion_fifo_pkg.sv ====
/*
 * constants, types and helpers shared by the motion sample buffer control.
 * assumes an 8-bit register space with 7-bit addresses and 16-bit buffer words.
 */
package motion_fifo_pkg;

    localparam int          ADDR_W      = 7;
    localparam int          DATA_W      = 8;
    localparam int          WORD_W      = 16;
    localparam int          PTR_W       = 12;
    localparam int          CNT_W       = 13;
    localparam int          NSETS       = 4;
    localparam int          DEC_W       = 3;
    localparam int          DCNT_W      = 6;
    localparam int          TCNT_W      = 10;
    localparam logic [CNT_W-1:0] DEPTH  = 13'h1000;

    localparam logic [ADDR_W-1:0] ADDR_THR_LO    = 7'h06;
    localparam logic [ADDR_W-1:0] ADDR_THR_HI    = 7'h07;
    localparam logic [ADDR_W-1:0] ADDR_DECIM     = 7'h08;
    localparam logic [ADDR_W-1:0] ADDR_EXTRA     = 7'h09;
    localparam logic [ADDR_W-1:0] ADDR_RATE_MODE = 7'h0a;
    localparam logic [ADDR_W-1:0] ADDR_OUT_LO    = 7'h3e;
    localparam logic [ADDR_W-1:0] ADDR_OUT_HI    = 7'h3f;

    localparam logic [DATA_W-1:0] REG_RST = 8'h00;
    localparam int STEP_EN_BIT   = 7;
    localparam int STEP_MODE_BIT = 6;
    localparam int THR_HI_LSB    = 0;
    localparam int THR_HI_W      = 4;
    localparam int GYRO_DEC_LSB  = 3;
    localparam int ACC_DEC_LSB   = 0;
    localparam int MSB_ONLY_BIT  = 6;
    localparam int DS4_DEC_LSB   = 3;
    localparam int DS3_DEC_LSB   = 0;
    localparam int RATE_LSB      = 3;
    localparam int RATE_W        = 4;
    localparam int MODE_LSB      = 0;

    localparam logic [DEC_W-1:0]  DEC_OFF   = 3'h0;
    localparam logic [RATE_W-1:0] RATE_OFF  = 4'h0;
    localparam logic [RATE_W-1:0] RATE_MAX  = 4'ha;

    localparam logic [2:0] MODE_BYPASS       = 3'h0;
    localparam logic [2:0] MODE_FIFO         = 3'h1;
    localparam logic [2:0] MODE_CONT_TO_FIFO = 3'h3;
    localparam logic [2:0] MODE_BYP_TO_CONT  = 3'h4;
    localparam logic [2:0] MODE_CONT         = 3'h6;

    typedef enum logic [1:0] {
        EM_BYPASS = 2'h0,
        EM_STOP   = 2'h1,
        EM_CONT   = 2'h3
    } eff_mode_t;

    function automatic logic [DCNT_W-1:0] decim_factor(input logic [DEC_W-1:0] code);
        unique case (code)
            3'h2:    decim_factor = 6'h02;
            3'h3:    decim_factor = 6'h03;
            3'h4:    decim_factor = 6'h04;
            3'h5:    decim_factor = 6'h08;
            3'h6:    decim_factor = 6'h10;
            3'h7:    decim_factor = 6'h20;
            default: decim_factor = 6'h01;
        endcase
    endfunction : decim_factor

    function automatic logic [RATE_W-1:0] rate_min(input logic [RATE_W-1:0] a,
                                                   input logic [RATE_W-1:0] b);
        rate_min = (a < b) ? a : b;
    endfunction : rate_min

endpackage : motion_fifo_pkg

// ==== inc/decim_if.sv ====
/*
 * carrier between the buffer control and one data-set decimator.
 * assumes both ends share the device clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface decim_if;
    logic [2:0] code;
    logic       tick;
    logic       keep;
    modport ctl (output code, output tick, input keep);
    modport dec (input code, input tick, output keep);
endinterface : decim_if
`default_nettype wire

// ==== hw/set_decimator.sv ====
/*
 * one-in-n sample keeper for a single buffer data set.
 * assumes tick is a one-cycle pulse per write event on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module set_decimator (
    input  wire logic clk,
    input  wire logic srst,
    decim_if.dec      dp
);
    import motion_fifo_pkg::*;

    logic [DCNT_W-1:0] cnt_r;
    logic [DCNT_W-1:0] cnt_nxt;
    logic [DCNT_W-1:0] factor;
    logic [DCNT_W-1:0] cur;

    assign factor  = decim_factor(dp.code);
    // a count left over from a larger factor restarts, so 001 never drops a sample
    assign cur     = (cnt_r >= factor) ? '0 : cnt_r;
    assign cnt_nxt = cur + 6'h01;
    // code 000 keeps nothing, otherwise the first of every n events
    assign dp.keep = dp.tick && (dp.code != DEC_OFF) && (cur == '0);

    always_ff @(posedge clk) begin
        if (srst || dp.code == DEC_OFF) begin
            cnt_r <= '0;
        end else if (dp.tick) begin
            cnt_r <= (cnt_nxt >= factor) ? '0 : cnt_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_decim_bound: assert property (cnt_r < 6'h20)
        else $error("decimation count out of range");
    a_decim_single: assert property ((dp.code == 3'h1) && dp.tick |-> dp.keep)
        else $error("undecimated set dropped a sample");
endmodule : set_decimator
`default_nettype wire

// ==== hw/motion_sample_fifo_control.sv ====
/*
 * batching buffer control: watermark, decimation, write source, store rate, modes
 * and the two read-out registers.
 * assumes data-ready, step and rate-base pulses come from logic on CLK, one cycle each;
 * the trigger level comes from elsewhere and is synchronised here.
 */
// The implementer's own choice: the plain strobed port.
// Notes on behaviour
// - watermark high when stored words plus one reach threshold.
// - threshold is 12 bits, low byte at 06h, upper nibble at 07h.
// - one threshold unit equals one two-byte stored word.
// - step-and-time enable adds or removes the fourth data set.
// - write mode selects data-ready writes or one write per detected step.
// - write mode only matters while hub data-valid select is low.
// - rate-sensor decimation: off, none, or keep one in 2..32.
// - accelerometer decimation uses the same eight codes.
// - third set decimation uses the same eight codes.
// - fourth set decimation uses the same eight codes.
// - msbyte-only stores just the upper byte of motion samples.
// - store rate 0000 disables, 0001..1010 select 12.5 Hz to 6.66 kHz.
// - store rate never exceeds the actual sensor output rate.
// - store rate applies only while hub select and write mode are low.
// - mode 000 is bypass; 010, 101, 111 are reserved.
// - mode 001 collects until full, then drops new writes.
// - mode 011 overwrites while triggered, stops when full after.
// - mode 100 bypasses while triggered, overwrites continuously after.
// - mode 110 overwrites the oldest word when full.
// - all fields reset to zero: disabled, bypass, threshold zero.
// - words are read through low byte 3Eh then high byte 3Fh.
`timescale 1ns/1ns
`default_nettype none
module motion_sample_fifo_control (
    input  wire logic                               CLK,
    input  wire logic                               SRST,
    input  wire logic [motion_fifo_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [motion_fifo_pkg::DATA_W-1:0] WDATA,
    input  wire logic                               WR,
    input  wire logic                               RD,
    output var  logic [motion_fifo_pkg::DATA_W-1:0] RDATA,
    input  wire logic                               GYRO_DRDY,
    input  wire logic                               ACCEL_DRDY,
    input  wire logic                               STEP_DETECT,
    input  wire logic                               RATE_BASE_TICK,
    input  wire logic [motion_fifo_pkg::RATE_W-1:0] SENSOR_RATE_CODE,
    input  wire logic                               HUB_DATA_VALID_SEL,
    input  wire logic                               TRIGGER,
    input  wire logic [motion_fifo_pkg::WORD_W-1:0] GYRO_DATA,
    input  wire logic [motion_fifo_pkg::WORD_W-1:0] ACCEL_DATA,
    input  wire logic [motion_fifo_pkg::WORD_W-1:0] SET3_DATA,
    input  wire logic [motion_fifo_pkg::WORD_W-1:0] STEP_DATA,
    output var  logic                               WATERMARK,
    output var  logic                               FULL_FLAG,
    output var  logic                               OVERRUN_FLAG
);
    import motion_fifo_pkg::*;

    logic [DATA_W-1:0]   thr_lo_r;
    logic [THR_HI_W-1:0] thr_hi_r;
    logic                step_en_r;
    logic                step_mode_r;
    logic [DEC_W-1:0]    dec_r [NSETS];
    logic                msb_only_r;
    logic [RATE_W-1:0]   rate_r;
    logic [2:0]          mode_r;
    logic [11:0]         thr;
    logic                trig_m_r;
    logic                trig_s_r;
    eff_mode_t           eff;
    logic [RATE_W-1:0]   eff_rate;
    logic [TCNT_W-1:0]   tick_cnt_r;
    logic [TCNT_W-1:0]   period_m1;
    logic                rate_tick;
    logic                drdy_seen_r;
    logic                write_event;
    logic [NSETS-1:0]    keep;
    logic [NSETS-1:0]    mask_r;
    logic [WORD_W-1:0]   data_r [NSETS];
    logic                load;
    logic [1:0]          sel;
    logic [WORD_W-1:0]   mem [DEPTH];
    logic [PTR_W-1:0]    wr_ptr_r;
    logic [PTR_W-1:0]    rd_ptr_r;
    logic [CNT_W-1:0]    count_r;
    logic [CNT_W-1:0]    count_nxt;
    logic                full;
    logic                do_pop;
    logic                push;
    logic                overwrite;
    logic                wm_cond;
    logic [WORD_W-1:0]   head;

    decim_if dif [NSETS] ();

    assign thr = {thr_hi_r, thr_lo_r};

    // control registers; only defined bits are kept so reserved bits read zero
    always_ff @(posedge CLK) begin
        if (SRST) begin
            thr_lo_r    <= REG_RST;
            thr_hi_r    <= '0;
            step_en_r   <= 1'b0;
            step_mode_r <= 1'b0;
            msb_only_r  <= 1'b0;
            rate_r      <= RATE_OFF;
            mode_r      <= MODE_BYPASS;
            for (int i = 0; i < NSETS; i++) begin
                dec_r[i] <= DEC_OFF;
            end
        end else if (WR) begin
            unique case (ADDR)
                ADDR_THR_LO: thr_lo_r <= WDATA;
                ADDR_THR_HI: begin
                    thr_hi_r    <= WDATA[THR_HI_LSB +: THR_HI_W];
                    step_en_r   <= WDATA[STEP_EN_BIT];
                    step_mode_r <= WDATA[STEP_MODE_BIT];
                end
                ADDR_DECIM: begin
                    dec_r[0] <= WDATA[GYRO_DEC_LSB +: DEC_W];
                    dec_r[1] <= WDATA[ACC_DEC_LSB +: DEC_W];
                end
                ADDR_EXTRA: begin
                    msb_only_r <= WDATA[MSB_ONLY_BIT];
                    dec_r[3]   <= WDATA[DS4_DEC_LSB +: DEC_W];
                    dec_r[2]   <= WDATA[DS3_DEC_LSB +: DEC_W];
                end
                ADDR_RATE_MODE: begin
                    rate_r <= WDATA[RATE_LSB +: RATE_W];
                    mode_r <= WDATA[MODE_LSB +: 3];
                end
                default: ;
            endcase
        end
    end

    // trigger crosses in from outside, so two flops before anything reads it
    always_ff @(posedge CLK) begin
        if (SRST) begin
            trig_m_r <= 1'b0;
            trig_s_r <= 1'b0;
        end else begin
            trig_m_r <= TRIGGER;
            trig_s_r <= trig_m_r;
        end
    end

    // reserved codes fall back to bypass rather than guessing a behaviour
    always_comb begin
        unique case (mode_r)
            MODE_BYPASS:       eff = EM_BYPASS;
            MODE_FIFO:         eff = EM_STOP;
            MODE_CONT_TO_FIFO: eff = trig_s_r ? EM_CONT : EM_STOP;
            MODE_BYP_TO_CONT:  eff = trig_s_r ? EM_BYPASS : EM_CONT;
            MODE_CONT:         eff = EM_CONT;
            default:           eff = EM_BYPASS;
        endcase
    end

    // the base tick runs at the top rate; each lower code halves it
    assign eff_rate  = rate_min(rate_min(rate_r, SENSOR_RATE_CODE), RATE_MAX);
    assign period_m1 = (10'h001 << (RATE_MAX - eff_rate)) - 10'h001;
    assign rate_tick = RATE_BASE_TICK && (eff_rate != RATE_OFF) && (tick_cnt_r >= period_m1);

    always_ff @(posedge CLK) begin
        if (SRST || eff_rate == RATE_OFF) begin
            tick_cnt_r <= '0;
        end else if (RATE_BASE_TICK) begin
            tick_cnt_r <= (tick_cnt_r >= period_m1) ? '0 : tick_cnt_r + 10'h001;
        end
    end

    // a data-ready arriving with the consuming tick re-arms, so it is not lost
    always_ff @(posedge CLK) begin
        if (SRST) begin
            drdy_seen_r <= 1'b0;
        end else if (GYRO_DRDY || ACCEL_DRDY) begin
            drdy_seen_r <= 1'b1;
        end else if (rate_tick) begin
            drdy_seen_r <= 1'b0;
        end
    end

    always_comb begin
        if (HUB_DATA_VALID_SEL) begin
            write_event = GYRO_DRDY || ACCEL_DRDY;
        end else if (step_mode_r) begin
            write_event = STEP_DETECT;
        end else begin
            write_event = rate_tick && drdy_seen_r;
        end
    end

    for (genvar g = 0; g < NSETS; g++) begin : g_dec
        assign dif[g].code = dec_r[g];
        assign dif[g].tick = write_event && (eff != EM_BYPASS);
        assign keep[g]     = dif[g].keep;
        set_decimator u_dec (
            .clk  (CLK),
            .srst (SRST),
            .dp   (dif[g])
        );
    end

    // a new event while the previous one is still draining is dropped
    assign load = write_event && (eff != EM_BYPASS) && (mask_r == '0);

    always_comb begin
        sel = 2'h0;
        for (int i = NSETS - 1; i >= 0; i--) begin
            if (mask_r[i]) begin
                sel = 2'(i);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST || eff == EM_BYPASS) begin
            mask_r <= '0;
        end else if (load) begin
            mask_r <= {keep[3] && step_en_r, keep[2:0]};
        end else if (mask_r != '0) begin
            mask_r[sel] <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            for (int i = 0; i < NSETS; i++) begin
                data_r[i] <= '0;
            end
        end else if (load) begin
            data_r[0] <= msb_only_r ? {8'h00, GYRO_DATA[15:8]} : GYRO_DATA;
            data_r[1] <= msb_only_r ? {8'h00, ACCEL_DATA[15:8]} : ACCEL_DATA;
            data_r[2] <= SET3_DATA;
            data_r[3] <= STEP_DATA;
        end
    end

    assign full      = (count_r == DEPTH);
    assign do_pop    = RD && (ADDR == ADDR_OUT_HI) && (count_r != '0);
    assign push      = (mask_r != '0) && (!full || do_pop || eff == EM_CONT);
    assign overwrite = push && full && !do_pop;
    assign count_nxt = count_r + {12'h000, push} - {12'h000, do_pop || overwrite};
    assign head      = (count_r != '0) ? mem[rd_ptr_r] : '0;

    // bypass empties the buffer; mode stop leaves a full buffer untouched
    always_ff @(posedge CLK) begin
        if (SRST || eff == EM_BYPASS) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 12'h001;
            end
            if (do_pop || overwrite) begin
                rd_ptr_r <= rd_ptr_r + 12'h001;
            end
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (push) begin
            mem[wr_ptr_r] <= data_r[sel];
        end
    end

    // counted in words, plus one whether or not a write is pending
    assign wm_cond = ({1'b0, count_r} + 14'h0001) >= {2'h0, thr};

    always_ff @(posedge CLK) begin
        if (SRST) begin
            WATERMARK    <= 1'b0;
            FULL_FLAG    <= 1'b0;
            OVERRUN_FLAG <= 1'b0;
        end else begin
            WATERMARK    <= wm_cond;
            FULL_FLAG    <= full;
            OVERRUN_FLAG <= overwrite;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            RDATA <= '0;
        end else if (RD) begin
            unique case (ADDR)
                ADDR_THR_LO:    RDATA <= thr_lo_r;
                ADDR_THR_HI:    RDATA <= {step_en_r, step_mode_r, 2'h0, thr_hi_r};
                ADDR_DECIM:     RDATA <= {2'h0, dec_r[0], dec_r[1]};
                ADDR_EXTRA:     RDATA <= {1'b0, msb_only_r, dec_r[3], dec_r[2]};
                ADDR_RATE_MODE: RDATA <= {1'b0, rate_r, mode_r};
                ADDR_OUT_LO:    RDATA <= head[7:0];
                ADDR_OUT_HI:    RDATA <= head[15:8];
                default:        RDATA <= '0;
            endcase
        end else begin
            RDATA <= '0;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    a_wm_follow: assert property (wm_cond |=> WATERMARK)
        else $error("watermark missed at threshold");
    a_thr_split: assert property (WR && ADDR == ADDR_THR_HI |=>
                                  thr[11:8] == $past(WDATA[3:0]))
        else $error("threshold upper nibble not taken");
    a_bypass_empty: assert property (eff == EM_BYPASS |=> count_r == '0)
        else $error("bypass left words stored");
    a_stop_full: assert property (eff == EM_STOP && full && !do_pop |=>
                                  $stable(wr_ptr_r) && count_r == DEPTH)
        else $error("stop mode wrote into full buffer");
    a_cont_over: assert property (eff == EM_CONT && full && push && !do_pop |=>
                                  rd_ptr_r == $past(rd_ptr_r) + 12'h001)
        else $error("oldest word not overwritten");
    a_trig_modes: assert property (mode_r == MODE_BYP_TO_CONT && !trig_s_r |->
                                   eff == EM_CONT)
        else $error("trigger release did not start continuous");
    a_trig_cont: assert property (mode_r == MODE_CONT_TO_FIFO |->
                                  eff == (trig_s_r ? EM_CONT : EM_STOP))
        else $error("trigger switched mode wrong");
    a_step_write: assert property (!HUB_DATA_VALID_SEL && step_mode_r |->
                                   write_event == STEP_DETECT)
        else $error("step write source ignored");
    a_rate_off: assert property (!HUB_DATA_VALID_SEL && !step_mode_r &&
                                 rate_r == RATE_OFF |-> !write_event)
        else $error("write with store rate disabled");
    a_rate_clamp: assert property (eff_rate <= SENSOR_RATE_CODE)
        else $error("store rate above sensor rate");
    a_step_excl: assert property (load && !step_en_r |=> !mask_r[3])
        else $error("fourth set stored while disabled");
    a_msb_only: assert property (load && msb_only_r |=> data_r[0][15:8] == 8'h00)
        else $error("full sample stored in msbyte mode");
    a_reset_zero: assert property (disable iff (1'b0) SRST |=>
                                   thr == '0 && mode_r == MODE_BYPASS)
        else $error("fields not cleared by reset");

    c_overwrite: cover property (overwrite);
    c_full_stop: cover property (eff == EM_STOP && full);
    c_pop_word:  cover property (do_pop ##1 RDATA != '0);
    c_trig_flip: cover property (mode_r == MODE_BYP_TO_CONT && $fell(trig_s_r));
endmodule : motion_sample_fifo_control
`default_nettype wire

// ==== bench/host_model.sv ====
/*
 * host processor model: drives the register port of the buffer control.
 * assumes the device answers a read in the cycle after the strobe.
 */
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic                              clk,
    output var  logic [motion_fifo_pkg::ADDR_W-1:0] addr,
    output var  logic [motion_fifo_pkg::DATA_W-1:0] wdata,
    output var  logic                              wr,
    output var  logic                              rd,
    input  wire logic [motion_fifo_pkg::DATA_W-1:0] rdata
);
    import motion_fifo_pkg::*;

    initial begin
        addr  = '0;
        wdata = '0;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // unused control bits are always sent as zero
    function automatic logic [DATA_W-1:0] used_bits(input logic [ADDR_W-1:0] a);
        case (a)
            ADDR_THR_HI:                 used_bits = 8'hcf;
            ADDR_DECIM:                  used_bits = 8'h3f;
            ADDR_EXTRA, ADDR_RATE_MODE:  used_bits = 8'h7f;
            default:                     used_bits = 8'hff;
        endcase
    endfunction : used_bits

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d & used_bits(a);
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~(d & used_bits(a));
    endtask : wr_reg

    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        @(posedge clk);
        d = rdata;
    endtask : rd_reg

    // low byte first: only the high byte read pops the word
    task automatic rd_word(output logic [WORD_W-1:0] w);
        logic [DATA_W-1:0] lo;
        logic [DATA_W-1:0] hi;
        rd_reg(ADDR_OUT_LO, lo);
        rd_reg(ADDR_OUT_HI, hi);
        w = {hi, lo};
    endtask : rd_word
endmodule : host_model
`default_nettype wire

// ==== bench/motion_sample_fifo_control_test.sv ====
/*
 * self-checking bench for the buffer control with random sample data.
 * assumes host_model drives the register port; sample strobes come from here.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module motion_sample_fifo_control_test;
    import motion_fifo_pkg::*;
    logic              clk = 1'b0;
    logic              srst, gyro_rdy, acc_rdy, step, tick, hub_sel, trig;
    logic              wr, rd, wmark, full, ovr;
    logic [RATE_W-1:0] sens_rate;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, rv, v;
    logic [WORD_W-1:0] gyro_d, acc_d, set3_d, step_d, w, e;
    logic [WORD_W-1:0] exp_q[$];
    int                fail_count, cmp_count, cycles, dummy, ovr_cnt;
    logic [ADDR_W-1:0] regs[5] = '{ADDR_THR_LO, ADDR_THR_HI, ADDR_DECIM, ADDR_EXTRA,
                                   ADDR_RATE_MODE};
    logic [DATA_W-1:0] msk[5] = '{8'hff, 8'hcf, 8'h3f, 8'h7f, 8'h7f};
    logic [11:0]       rtab[4] = '{12'haa4, 12'h9a2, 12'ha92, 12'h0a0};
    logic [DATA_W-1:0] bmode[4] = '{8'h00, 8'h02, 8'h05, 8'h07};

    motion_sample_fifo_control u_dut (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .GYRO_DRDY(gyro_rdy), .ACCEL_DRDY(acc_rdy),
        .STEP_DETECT(step), .RATE_BASE_TICK(tick), .SENSOR_RATE_CODE(sens_rate),
        .HUB_DATA_VALID_SEL(hub_sel), .TRIGGER(trig), .GYRO_DATA(gyro_d),
        .ACCEL_DATA(acc_d), .SET3_DATA(set3_d), .STEP_DATA(step_d), .WATERMARK(wmark),
        .FULL_FLAG(full), .OVERRUN_FLAG(ovr));
    host_model u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));

    always #5 clk = ~clk;

    // overrun is a one-cycle pulse per word, so pulses are counted here
    always @(posedge clk) begin
        cycles++;
        if (ovr === 1'b1) ovr_cnt++;
        if (cycles == 40000) begin
            fail_count++;
            final_report();
        end
    end

    function automatic int fac(input int c);
        case (c)
            5:       fac = 8;
            6:       fac = 16;
            7:       fac = 32;
            default: fac = c;
        endcase
    endfunction : fac

    task automatic newdata();
        @(posedge clk);
        gyro_d <= 16'($urandom) | 16'h0101;
        acc_d  <= 16'($urandom) | 16'h0101;
        set3_d <= 16'($urandom) | 16'h0101;
        step_d <= 16'($urandom) | 16'h0101;
    endtask : newdata

    // spacing of six cycles leaves room for four words to drain
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0:       gyro_rdy <= 1'b1;
            1:       acc_rdy <= 1'b1;
            2:       step <= 1'b1;
            default: tick <= 1'b1;
        endcase
        @(posedge clk);
        {gyro_rdy, acc_rdy, step, tick} <= 4'h0;
        repeat (4) @(posedge clk);
    endtask : pulse

    task automatic cfg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
                       input logic [7:0] d);
        u_host.wr_reg(ADDR_THR_HI, a);
        u_host.wr_reg(ADDR_DECIM, b);
        u_host.wr_reg(ADDR_EXTRA, c);
        u_host.wr_reg(ADDR_RATE_MODE, d);
    endtask : cfg

    task automatic drain();
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            u_host.rd_word(w);
            `CHK("word", e, w)
        end
        u_host.rd_word(w);
        `CHK("empty read", 16'h0000, w)
    endtask : drain

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    initial begin
        dummy = $urandom(32'hbcd4);
        {gyro_rdy, acc_rdy, step, tick, hub_sel, trig} = '0;
        {cycles, fail_count, cmp_count, ovr_cnt} = '0;
        sens_rate = RATE_MAX;
        srst = 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        newdata();
        `CHK("watermark in reset", 1'b0, wmark)
        repeat (2) @(posedge clk);
        `CHK("watermark at zero", 1'b1, wmark)
        foreach (regs[i]) begin
            u_host.rd_reg(regs[i], rv);
            `CHK("reset value", 8'h00, rv)
            v = 8'($urandom);
            u_host.wr_reg(regs[i], v);
            u_host.rd_reg(regs[i], rv);
            `CHK("readback", v & msk[i], rv)
        end
        u_host.wr_reg(7'h20, 8'h5a);
        u_host.rd_reg(7'h20, rv);
        `CHK("unmapped", 8'h00, rv)
        hub_sel <= 1'b1;
        u_host.wr_reg(ADDR_THR_LO, 8'h03);
        cfg(8'h00, 8'h09, 8'h00, 8'h06);
        pulse(0);
        `CHK("watermark two words", 1'b1, wmark)
        u_host.rd_word(w);
        `CHK("first word", gyro_d, w)
        repeat (2) @(posedge clk);
        `CHK("watermark one word", 1'b0, wmark)
        exp_q.push_back(acc_d);
        drain();
        cfg(8'h40, 8'h09, 8'h00, 8'h06);
        pulse(2);
        drain();
        cfg(8'h00, 8'h09, 8'h40, 8'h06);
        pulse(1);
        exp_q.push_back({8'h00, gyro_d[15:8]});
        exp_q.push_back({8'h00, acc_d[15:8]});
        drain();
        for (int c = 1; c < 8; c++) begin
            newdata();
            cfg(8'h80, 8'h00, 8'h00, 8'h06);
            cfg(8'h80, 8'(c * 9), 8'(c * 9), 8'h06);
            repeat (2 * fac(c)) pulse(0);
            repeat (2) exp_q = {exp_q, gyro_d, acc_d, set3_d, step_d};
            drain();
        end
        hub_sel <= 1'b0;
        cfg(8'hc0, 8'h00, 8'h08, 8'h06);
        pulse(0);
        pulse(2);
        exp_q.push_back(step_d);
        drain();
        cfg(8'h40, 8'h00, 8'h08, 8'h06);
        pulse(2);
        drain();
        cfg(8'h00, 8'h01, 8'h00, 8'h06);
        foreach (rtab[i]) begin
            u_host.wr_reg(ADDR_RATE_MODE, {1'b0, rtab[i][11:8], 3'h6});
            sens_rate <= rtab[i][7:4];
            repeat (4) begin
                pulse(1);
                pulse(3);
            end
            repeat (rtab[i][3:0]) exp_q.push_back(acc_d);
            drain();
        end
        hub_sel <= 1'b1;
        trig <= 1'b1;
        cfg(8'h00, 8'h09, 8'h00, 8'h04);
        pulse(0);
        drain();
        trig <= 1'b0;
        repeat (4) @(posedge clk);
        pulse(0);
        exp_q = {gyro_d, acc_d};
        drain();
        trig <= 1'b1;
        u_host.wr_reg(ADDR_RATE_MODE, 8'h03);
        repeat (4) @(posedge clk);
        pulse(0);
        exp_q = {gyro_d, acc_d};
        drain();
        foreach (bmode[i]) begin
            u_host.wr_reg(ADDR_RATE_MODE, bmode[i]);
            pulse(0);
            drain();
        end
        trig <= 1'b0;
        u_host.wr_reg(ADDR_RATE_MODE, 8'h01);
        repeat (2048) pulse(0);
        pulse(0);
        `CHK("full", 1'b1, full)
        `CHK("no overwrite", 0, ovr_cnt)
        u_host.wr_reg(ADDR_RATE_MODE, 8'h06);
        pulse(0);
        `CHK("overwrite", 2, ovr_cnt)
        u_host.wr_reg(ADDR_RATE_MODE, 8'h00);
        repeat (3) @(posedge clk);
        `CHK("flushed", 1'b0, full)
        final_report();
    end
endmodule : motion_sample_fifo_control_test
`default_nettype wire
